// ==== rdt_defs.svh ====
`ifndef RDT_DEFS_SVH
`define RDT_DEFS_SVH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------
`define RDT_CMD_IDX 16'h1C09
`define RDT_WDATA_IDX 16'h1C0A
`define RDT_RDATA_IDX 16'h1C0B
`define RDT_EGCFG_IDX 16'h1C0C

// ----------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------
`define RDT_CMD_READ_BIT 4
`define RDT_PROB_W 10
`define RDT_EGCFG_MASK 32'h007F7F7F
`define RDT_PORT_FIELD_W 7
`define RDT_PROB_RST 10'h000
`define RDT_EGCFG_RST 32'h00000000
`define RDT_CMD_RST 5'h00
`define RDT_LFSR_SEED 10'h2A5

`endif

// ==== rdt_discard_tag_cfg.sv ====
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "rdt_defs.svh"

module rdt_discard_tag_cfg (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic [15:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [31:0] rdata,
	// Random discard decision
	input wire logic dscReq,
	input wire logic dscYellow,
	input wire logic [7:0] dscBufUsed,
	output logic dscValid,
	output logic dscDrop,
	// Egress tag editing
	input wire logic tagReq,
	input wire rdt_pkg::rdt_tag_req_s tagIn,
	output logic tagValid,
	output rdt_pkg::rdt_tag_act_s tagAct
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_CMD = 16'(`RDT_CMD_IDX * 4);
	localparam logic [15:0] ADDR_WD = 16'(`RDT_WDATA_IDX * 4);
	localparam logic [15:0] ADDR_RD = 16'(`RDT_RDATA_IDX * 4);
	localparam logic [15:0] ADDR_EG = 16'(`RDT_EGCFG_IDX * 4);

	logic [9:0] weight [16];
	logic [9:0] wdata_r;
	logic [9:0] rdTbl_r;
	logic [4:0] cmd_r;
	logic [31:0] egCfg_r;
	logic [9:0] lfsr_r;
	logic [9:0] rnd;
	logic [3:0] dscIdx;
	logic cmdWr;
	logic cmdRead;
	logic [31:0] rdata_nxt;
	rdt_pkg::rdt_port_cfg_s pc;
	rdt_pkg::rdt_tag_act_s act_nxt;

	// A command is any write to the command register.
	assign cmdWr = ce && wrEn && (addr == ADDR_CMD);
	assign cmdRead = wdata[`RDT_CMD_READ_BIT];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------

	// Write-data holding register; only the probability bits are kept.
	always_ff @(posedge clk)
	begin
		if (rst)
			wdata_r <= `RDT_PROB_RST;
		else if (ce && wrEn && addr == ADDR_WD)
			wdata_r <= wdata[9:0];
	end

	// Last command is kept so software can read back what it issued.
	always_ff @(posedge clk)
	begin
		if (rst)
			cmd_r <= `RDT_CMD_RST;
		else if (cmdWr)
			cmd_r <= wdata[4:0];
	end

	// Reserved bits are masked on write so they can never be set.
	always_ff @(posedge clk)
	begin
		if (rst)
			egCfg_r <= `RDT_EGCFG_RST;
		else if (ce && wrEn && addr == ADDR_EG)
			egCfg_r <= wdata & `RDT_EGCFG_MASK;
	end

	// ----------------------------------------------------------------
	// Discard weight table
	// ----------------------------------------------------------------

	// The table has no reset on purpose: it stays undefined until written.
	always_ff @(posedge clk)
	begin
		if (cmdWr && !cmdRead)
			weight[wdata[3:0]] <= wdata_r;
	end

	// Read commands latch the entry into the read-data register.
	always_ff @(posedge clk)
	begin
		if (rst)
			rdTbl_r <= `RDT_PROB_RST;
		else if (cmdWr && cmdRead)
			rdTbl_r <= weight[wdata[3:0]];
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------

	// Unmapped addresses read as zero; upper bits of narrow fields are zero.
	always_comb
	begin
		rdata_nxt = 32'h00000000;
		unique case (addr)
			ADDR_CMD: rdata_nxt = {27'h0000000, cmd_r};
			ADDR_WD: rdata_nxt = {22'h000000, wdata_r};
			ADDR_RD: rdata_nxt = {22'h000000, rdTbl_r};
			ADDR_EG: rdata_nxt = egCfg_r;
			default: rdata_nxt = 32'h00000000;
		endcase
	end

	// Read data stand in the cycle after the strobe and are held for as long as the enable then stays low.
	always_ff @(posedge clk)
	begin
		if (rst)
			rdata <= 32'h00000000;
		else if (ce)
			rdata <= rdEn ? rdata_nxt : 32'h00000000;
	end

	// ----------------------------------------------------------------
	// Random discard
	// ----------------------------------------------------------------

	// Coarser steps at high usage keep fine control where drops start.
	always_comb
	begin
		if (dscBufUsed < 8'h40)
			dscIdx = {1'b0, dscBufUsed[5:3]};
		else if (dscBufUsed < 8'h80)
			dscIdx = {2'h2, dscBufUsed[5:4]};
		else
			dscIdx = {2'h3, dscBufUsed[6:5]};
	end

	// Maximal-length LFSR; it never holds zero, so one is subtracted.
	always_ff @(posedge clk)
	begin
		if (rst)
			lfsr_r <= `RDT_LFSR_SEED;
		else if (ce)
			lfsr_r <= {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
	end

	// A weight of 1023 drops every time, since rnd never exceeds 1022.
	assign rnd = lfsr_r - 10'h001;

	// Only Yellow packets are subject to the weight.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dscValid <= 1'b0;
			dscDrop <= 1'b0;
		end
		else if (ce)
		begin
			dscValid <= dscReq;
			dscDrop <= dscReq && dscYellow && (rnd < weight[dscIdx]);
		end
	end

	// ----------------------------------------------------------------
	// Egress tag editing
	// ----------------------------------------------------------------

	// Port 3 has no field and is treated as non-Hybrid.
	assign pc = rdt_pkg::rdt_port_cfg_s'(egCfg_r[{tagIn.port, 3'h0} +: `RDT_PORT_FIELD_W]);

	// The four edit flags stay clear unless the port is Hybrid.
	always_comb
	begin
		act_nxt = '0;
		act_nxt.etype = pc.etype;
		act_nxt.vid = pc.sel ? tagIn.egrVid : tagIn.ingVid;
		act_nxt.pri = pc.sel ? tagIn.egrPri : tagIn.ingPri;
		if (tagIn.port != 2'h3 && pc.etype == rdt_pkg::ETYPE_HYBRID)
		begin
			case (tagIn.kind)
				rdt_pkg::KIND_UNTAGGED:
					act_nxt.insertTag = pc.ins && !tagIn.untagDefault;
				rdt_pkg::KIND_PRIO:
				begin
					if (tagIn.untagIncoming)
						act_nxt.removeTag = 1'b1;
					else
					begin
						act_nxt.changeVid = 1'b1;
						act_nxt.changePri = pc.chgPri;
					end
				end
				rdt_pkg::KIND_REGULAR:
				begin
					if (pc.chgTag && (pc.chgVid || pc.chgPri))
					begin
						if (tagIn.untagIncoming)
							act_nxt.removeTag = 1'b1;
						else
						begin
							act_nxt.changeVid = pc.chgVid;
							act_nxt.changePri = pc.chgPri;
						end
					end
				end
				default: act_nxt.removeTag = 1'b0;
			endcase
		end
	end

	// Decision is registered so the datapath sees a stable word.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tagValid <= 1'b0;
			tagAct <= '0;
		end
		else if (ce)
		begin
			tagValid <= tagReq;
			tagAct <= act_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence seqCmdRead;
		ce && wrEn && addr == ADDR_CMD && wdata[4];
	endsequence

	sequence seqCmdWrite;
		ce && wrEn && addr == ADDR_CMD && !wdata[4];
	endsequence

	sequence seqReadBack;
		ce && rdEn && addr == ADDR_RD;
	endsequence

	tbl_read_a: assert property (@(posedge clk) disable iff (rst)
		seqCmdRead |=> rdTbl_r == weight[$past(wdata[3:0])])
		else $error("Table read did not load read data.");

	tbl_write_a: assert property (@(posedge clk) disable iff (rst)
		seqCmdWrite |=> weight[$past(wdata[3:0])] == $past(wdata_r))
		else $error("Table write did not store write data.");

	read_chain_a: assert property (@(posedge clk) disable iff (rst)
		seqCmdRead ##1 seqReadBack |=> rdata == {22'h000000, weight[$past(wdata[3:0], 2)]})
		else $error("Read command then read-back returned wrong entry.");

	narrow_read_a: assert property (@(posedge clk) disable iff (rst)
		ce && rdEn && (addr == ADDR_WD || addr == ADDR_RD) |=> rdata[31:10] == 22'h000000)
		else $error("Reserved bits of a table data register read nonzero.");

	egcfg_resv_a: assert property (@(posedge clk) disable iff (rst)
		(egCfg_r & ~`RDT_EGCFG_MASK) == 32'h00000000)
		else $error("Reserved egress config bits are set.");

	usage_map_a: assert property (@(posedge clk) disable iff (rst)
		dscBufUsed >= 8'h80 |-> dscIdx == 4'(8'h0C + ((dscBufUsed - 8'h80) >> 5)))
		else $error("High buffer usage mapped to wrong entry.");

	green_keep_a: assert property (@(posedge clk) disable iff (rst)
		ce && dscReq && !dscYellow |=> dscValid && !dscDrop)
		else $error("Non-Yellow packet was dropped.");

	rnd_drop_a: assert property (@(posedge clk) disable iff (rst)
		ce && dscReq && dscYellow && rnd < weight[dscIdx] |=> dscDrop)
		else $error("Yellow packet below weight was kept.");

	not_hybrid_a: assert property (@(posedge clk) disable iff (rst)
		ce && tagReq && pc.etype != rdt_pkg::ETYPE_HYBRID |=>
			!tagAct.insertTag && !tagAct.changeVid && !tagAct.changePri && !tagAct.removeTag)
		else $error("Tag edit acted on a non-Hybrid port.");

	chg_tag_gate_a: assert property (@(posedge clk) disable iff (rst)
		ce && tagReq && tagIn.kind == rdt_pkg::KIND_REGULAR && !pc.chgTag |=>
			!tagAct.changeVid && !tagAct.changePri && !tagAct.removeTag)
		else $error("Regular tagged packet edited without change tag.");

endmodule : rdt_discard_tag_cfg

// ==== rdt_discard_tag_cfg_tb.sv ====
`timescale 1ns/1ps
`include "rdt_defs.svh"

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
	$display("unexpected %s exp %0h got %0h", nm, ex, got); end end

module rdt_discard_tag_cfg_tb;

	// ----------------------------------------------------------------
	// Bench state.
	// ----------------------------------------------------------------
	localparam logic [15:0] CMD = 16'(`RDT_CMD_IDX * 4);
	localparam logic [15:0] WD = 16'(`RDT_WDATA_IDX * 4);
	localparam logic [15:0] RD = 16'(`RDT_RDATA_IDX * 4);
	localparam logic [15:0] EG = 16'(`RDT_EGCFG_IDX * 4);
	logic clk = 0, rst = 1, ce = 1, wrEn = 0, rdEn = 0, dscReq = 0, dscYellow = 0, tagReq = 0;
	logic [15:0] addr = '0;
	logic [31:0] wdata = '0, rdata, e32, egModel = '0;
	logic [7:0] dscBufUsed = '0;
	logic dscValid, dscDrop, tagValid, rdSeen = 0, e1;
	rdt_pkg::rdt_tag_req_s tagIn = '0;
	rdt_pkg::rdt_tag_act_s tagAct, eAct;
	logic [9:0] tbl [16];
	logic [31:0] expRd [$];
	logic expDrop [$];
	rdt_pkg::rdt_tag_act_s expTag [$];
	int num_errors = 0, tests_run = 0;
	// Usage values on both sides of every range change.
	logic [7:0] slotEdges [12] = '{0, 7, 8, 63, 64, 79, 80, 127, 128, 159, 224, 255};

	rdt_discard_tag_cfg u_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
		.wrEn(wrEn), .rdEn(rdEn), .rdata(rdata), .dscReq(dscReq), .dscYellow(dscYellow),
		.dscBufUsed(dscBufUsed), .dscValid(dscValid), .dscDrop(dscDrop), .tagReq(tagReq),
		.tagIn(tagIn), .tagValid(tagValid), .tagAct(tagAct));

	// Free-running core clock.
	initial forever #5 clk = ~clk;

	// ----------------------------------------------------------------
	// Reference models.
	// ----------------------------------------------------------------
	// Usage to entry mapping, finer steps at low usage.
	function automatic logic [3:0] slot(input logic [7:0] u);
		if (u < 64) return 4'(u / 8);
		if (u < 128) return 4'(8 + (u - 64) / 16);
		return 4'(12 + (u - 128) / 32);
	endfunction : slot

	// Tag decision from the configuration the bench last wrote.
	function automatic rdt_pkg::rdt_tag_act_s decide(input rdt_pkg::rdt_tag_req_s t);
		rdt_pkg::rdt_port_cfg_s f;
		rdt_pkg::rdt_tag_act_s a;
		f = rdt_pkg::rdt_port_cfg_s'(egModel[8 * t.port +: 7]);
		a = '0;
		a.etype = f.etype;
		a.vid = f.sel ? t.egrVid : t.ingVid;
		a.pri = f.sel ? t.egrPri : t.ingPri;
		if (f.etype == rdt_pkg::ETYPE_HYBRID)
		begin
			if (t.kind == rdt_pkg::KIND_UNTAGGED)
				a.insertTag = f.ins & ~t.untagDefault;
			else if (t.kind == rdt_pkg::KIND_PRIO)
			begin
				a.removeTag = t.untagIncoming;
				a.changeVid = ~t.untagIncoming;
				a.changePri = f.chgPri & ~t.untagIncoming;
			end
			else if (f.chgTag & (f.chgVid | f.chgPri))
			begin
				a.removeTag = t.untagIncoming;
				a.changeVid = f.chgVid & ~t.untagIncoming;
				a.changePri = f.chgPri & ~t.untagIncoming;
			end
		end
		return a;
	endfunction : decide

	// ----------------------------------------------------------------
	// Drivers; every strobe is set once per edge, so back to back is safe.
	// ----------------------------------------------------------------
	task automatic step(input logic [3:0] k, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		wrEn <= k[0];
		rdEn <= k[1];
		dscReq <= k[2];
		tagReq <= k[3];
		addr <= a;
		wdata <= d;
	endtask : step

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		step(4'h1, a, d);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		step(4'h2, a, $urandom);
		expRd.push_back(e);
	endtask : rd

	// Loads all entries with junk above bit 9, then reads every one back.
	task automatic load(input bit rnd, input logic [15:0] pat);
		logic [31:0] v;
		for (int i = 0; i < 16; i++)
		begin
			v = $urandom;
			if (!rnd) v[9:0] = {10{pat[i]}};
			tbl[i] = v[9:0];
			wr(WD, v);
			rd(WD, {22'h0, v[9:0]});
			wr(CMD, ($urandom & 32'hFFFFFFE0) | 32'(i));
		end
		for (int i = 0; i < 16; i++)
		begin
			wr(CMD, 32'hFFFFFFF0 | 32'(i));
			rd(RD, {22'h0, tbl[i]});
			rd(CMD, 32'h10 | 32'(i));
		end
	endtask : load

	task automatic dsc(input logic y, input logic [7:0] u);
		step(4'h4, 16'h0, 32'h0);
		dscYellow <= y;
		dscBufUsed <= u;
		expDrop.push_back(y & (tbl[slot(u)] == 10'h3FF));
	endtask : dsc

	task automatic tag();
		rdt_pkg::rdt_tag_req_s t;
		t = rdt_pkg::rdt_tag_req_s'(36'({$urandom, $urandom}));
		t.port = 2'($urandom_range(2));
		t.kind = rdt_pkg::rdt_kind_e'(2'($urandom_range(2)));
		step(4'h8, 16'h0, 32'h0);
		tagIn <= t;
		expTag.push_back(decide(t));
	endtask : tag

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// Result watcher: pops the oldest note whenever an answer shows.
	// ----------------------------------------------------------------
	always @(posedge clk)
	begin
		rdSeen <= rdEn;
		if (rdSeen)
		begin
			e32 = expRd.pop_front();
			`CHK("rdata", e32, rdata)
		end
		if (dscValid)
		begin
			e1 = expDrop.pop_front();
			`CHK("dscDrop", e1, dscDrop)
		end
		if (tagValid)
		begin
			eAct = expTag.pop_front();
			`CHK("tagAct", eAct, tagAct)
		end
	end

	// Watchdog; the whole run needs well under a thousand cycles.
	initial
	begin
		#50000;
		num_errors++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial
	begin
		logic [15:0] pat;
		logic [31:0] cfg;
		void'($urandom(32'h7F583703));
		repeat (3) @(posedge clk);
		rst <= 0;
		rd(WD, 0);
		rd(RD, 0);
		rd(EG, 0);
		rd(CMD, 0);
		$display("test reset_values done");
		load(1, 16'h0);
		wr(RD, 32'hFFFFFFFF);
		rd(RD, {22'h0, tbl[15]});
		wr(16'h7040, 32'hFFFFFFFF);
		rd(16'h7040, 0);
		step(4'h0, 16'h0, 32'h0);
		$display("test table_access done");
		// Writes while the enable is low must leave every register as it was.
		ce <= 0;
		wr(EG, 32'hFFFFFFFF);
		wr(WD, {22'h0, ~tbl[15]});
		step(4'h0, 16'h0, 32'h0);
		ce <= 1;
		rd(EG, 0);
		rd(WD, {22'h0, tbl[15]});
		$display("test clock_enable done");
		pat = 16'($urandom);
		for (int p = 0; p < 2; p++)
		begin
			load(0, p ? ~pat : pat);
			foreach (slotEdges[j]) dsc(1, slotEdges[j]);
			repeat (40) dsc(1'($urandom), 8'($urandom));
		end
		$display("test random_discard done");
		for (int n = 0; n < 8; n++)
		begin
			cfg = $urandom;
			if (n % 2 == 0) cfg = (cfg & 32'hFFFCFCFC) | 32'h00020202;
			wr(EG, cfg);
			egModel = cfg & `RDT_EGCFG_MASK;
			rd(EG, egModel);
			repeat (24) tag();
		end
		$display("test tag_editing done");
		// A mid-run reset clears the registers but must leave the table alone.
		step(4'h0, 16'h0, 32'h0);
		rst <= 1;
		step(4'h0, 16'h0, 32'h0);
		rst <= 0;
		rd(EG, 0);
		rd(WD, 0);
		wr(CMD, 32'h0000001F);
		rd(RD, {22'h0, tbl[15]});
		$display("test mid_reset done");
		step(4'h0, 16'h0, 32'h0);
		repeat (4) @(posedge clk);
		`CHK("pendingNotes", 0, expRd.size() + expDrop.size() + expTag.size())
		print_verdict();
	end

endmodule : rdt_discard_tag_cfg_tb

// ==== rdt_pkg.sv ====
package rdt_pkg;

	// Egress port type codes.
	typedef enum logic [1:0] {
		ETYPE_PASS = 2'h0,
		ETYPE_STRIP = 2'h1,
		ETYPE_HYBRID = 2'h2,
		ETYPE_SRCTAG = 2'h3
	} rdt_etype_e;

	// Tag state of a packet at egress.
	typedef enum logic [1:0] {
		KIND_UNTAGGED = 2'h0,
		KIND_PRIO = 2'h1,
		KIND_REGULAR = 2'h2
	} rdt_kind_e;

	// One port's field of the egress tag edit register, MSB first.
	typedef struct packed {
		logic sel;
		logic ins;
		logic chgVid;
		logic chgPri;
		logic chgTag;
		rdt_etype_e etype;
	} rdt_port_cfg_s;

	// Facts about one egress packet.
	typedef struct packed {
		logic [1:0] port;
		rdt_kind_e kind;
		logic untagDefault;
		logic untagIncoming;
		logic [11:0] ingVid;
		logic [2:0] ingPri;
		logic [11:0] egrVid;
		logic [2:0] egrPri;
	} rdt_tag_req_s;

	// Editing decision for that packet.
	typedef struct packed {
		rdt_etype_e etype;
		logic insertTag;
		logic changeVid;
		logic changePri;
		logic removeTag;
		logic [11:0] vid;
		logic [2:0] pri;
	} rdt_tag_act_s;

endpackage : rdt_pkg
